// ### hw/xabd_map.svh
`ifndef XABD_MAP_SVH
`define XABD_MAP_SVH

// ****************************************
// Opcode bytes
// ****************************************
`define XABD_OPC_ADJ_ADD     8'h37
`define XABD_OPC_ADJ_SUB     8'h3f
`define XABD_OPC_ADJ_DIV     8'hd5
`define XABD_OPC_ADJ_MUL     8'hd4
`define XABD_OPC_ADJ_BASE    8'h0a
`define XABD_OPC_ESC         8'h0f
`define XABD_OPC_PRIV        8'h63
`define XABD_OPC_BOUND       8'h62
`define XABD_OPC_SCAN_FWD    8'hbc
`define XABD_OPC_SCAN_REV    8'hbd
`define XABD_OPC_BIT_GRP     8'hba
`define XABD_OPC_BIT_TEST    8'ha3
`define XABD_OPC_BIT_CPL     8'hbb
`define XABD_OPC_BIT_CLR     8'hb3
`define XABD_OPC_BIT_SET     8'hab
`define XABD_HI_ADD          4'h0
`define XABD_HI_ADC          4'h1
`define XABD_HI_AND          4'h2
`define XABD_HI_IMM_GRP      4'h8
`define XABD_LO_MODRM_GRP    2'h0
`define XABD_LO_IMM_ACC      3'h2
`define XABD_SUB_ADD         3'h0
`define XABD_SUB_ADC         3'h2
`define XABD_SUB_AND         3'h4
`define XABD_SUB_BIT_TEST    3'h4
`define XABD_SUB_BIT_SET     3'h5
`define XABD_SUB_BIT_CLR     3'h6
`define XABD_SUB_BIT_CPL     3'h7

// ****************************************
// Field positions and codes
// ****************************************
`define XABD_F_HI            7:4
`define XABD_F_LO            3:0
`define XABD_F_LO_GRP        3:2
`define XABD_F_LO_ACC        3:1
`define XABD_B_W             0
`define XABD_B_D             1
`define XABD_B_S             1
`define XABD_F_MOD           7:6
`define XABD_F_REG           5:3
`define XABD_F_RM            2:0
`define XABD_F_SS            7:6
`define XABD_F_IDX           5:3
`define XABD_F_BASE          2:0
`define XABD_MOD_REG         2'h3
`define XABD_MOD_NODISP      2'h0
`define XABD_RM_SIB          3'h4
`define XABD_IDX_NONE        3'h4
`define XABD_BASE_DISP       3'h5
`define XABD_SS_ONE          2'h0
`define XABD_MODRM_NONE      8'hc0
`define XABD_SIB_NONE        8'h00
`define XABD_BOUND_VEC       8'h05

// ****************************************
// Clock counts
// ****************************************
`define XABD_CLK_ASCII       8'h04
`define XABD_CLK_ASCII_MUL   8'h10
`define XABD_CLK_ALU_REG     8'h01
`define XABD_CLK_ALU_MEM     8'h03
`define XABD_CLK_ALU_MISS    8'h05
`define XABD_CLK_PRIV_REG    8'h06
`define XABD_CLK_PRIV_MEM    8'h0a
`define XABD_CLK_PRIV_MISS   8'h0a
`define XABD_CLK_BOUND       8'h0b
`define XABD_CLK_SCAN_REG    8'h05
`define XABD_CLK_SCAN_MEM    8'h07
`define XABD_CLK_SCAN_MISS   8'h09
`define XABD_CLK_BTI_REG     8'h03
`define XABD_CLK_BTI_MEM     8'h04
`define XABD_CLK_BTI_MISS    8'h05
`define XABD_CLK_BTR_REG     8'h03
`define XABD_CLK_BTR_MEM     8'h06
`define XABD_CLK_BTR_MISS    8'h07
`define XABD_CLK_MODI_REG    8'h04
`define XABD_CLK_MODI_MEM    8'h05
`define XABD_CLK_MODI_MISS   8'h06
`define XABD_CLK_MODR_REG    8'h05
`define XABD_CLK_MODR_MEM    8'h08
`define XABD_CLK_MODR_MISS   8'h09
`define XABD_CLK_SETI_REG    8'h03
`define XABD_CLK_SETI_MEM    8'h05
`define XABD_CLK_SETI_MISS   8'h06
`define XABD_CLK_SETR_REG    8'h04
`define XABD_CLK_SETR_MEM    8'h07
`define XABD_CLK_SETR_MISS   8'h08
`define XABD_CLK_EA_TWO      8'h01
`define XABD_CLK_MIS_RW      8'h02
`define XABD_CLK_MIS_RMW     8'h04
`define XABD_CLK_INVALID     8'h01
`define XABD_CNT_LAST        8'h01
`define XABD_CLK_ZERO        8'h00

`endif

// ### hw/xabd_pkg.sv
package xabd_pkg;

	typedef enum logic [3:0] {
		OP_INVALID,
		OP_ASCII_ADJUST_AFTER_ADD,
		OP_ASCII_ADJUST_BEFORE_DIVIDE,
		OP_ASCII_ADJUST_AFTER_MULTIPLY,
		OP_ASCII_ADJUST_AFTER_SUBTRACT,
		OP_ADD,
		OP_ADD_CARRY,
		OP_BOOL_AND,
		OP_PRIVILEGE_LEVEL_ADJUST,
		OP_BOUND_CHECK,
		OP_FORWARD_BIT_SCAN,
		OP_REVERSE_BIT_SCAN,
		OP_BIT_TEST,
		OP_BIT_TEST_COMPLEMENT,
		OP_BIT_TEST_CLEAR,
		OP_BIT_TEST_SET
	} xabd_op_t;

	typedef enum logic [2:0] {
		FORM_IMPLIED,
		FORM_REG_REG,
		FORM_REG_TO_MEM,
		FORM_MEM_TO_REG,
		FORM_IMM_TO_RM,
		FORM_IMM_TO_ACC,
		FORM_RM_IMM,
		FORM_RM_REG
	} xabd_form_t;

	typedef enum logic [2:0] {
		ST_OPCODE,
		ST_ESCAPE,
		ST_ASCII_BASE,
		ST_MODRM,
		ST_SIB,
		ST_LOAD,
		ST_EXEC
	} xabd_state_t;

	typedef struct packed {
		logic       prot_mode;
		logic       cache_miss;
		logic       misaligned;
		logic       out_of_range;
		logic [5:0] scan_n;
	} xabd_ctx_t;

	typedef struct packed {
		xabd_op_t   op;
		xabd_form_t form;
		logic       mem_operand;
		logic       full_width;
		logic       reg_is_dest;
		logic       sign_ext_imm;
		logic       clear_overflow_carry;
		logic       mod_zero_flag;
		logic       raise_vector;
		logic [7:0] vector;
		logic       invalid;
		logic       ea_undefined;
		logic [3:0] scale;
		logic [7:0] clocks;
	} xabd_result_t;

endpackage

// ### hw/xabd_ea_cost.sv
`timescale 1ns/1ps

`include "xabd_map.svh"

module xabd_ea_cost (
	input  wire logic [7:0] modrm,
	input  wire logic [7:0] sib,
	output logic            two_reg,
	output logic [3:0]      scale,
	output logic            ea_undef
);

	logic has_sib;
	logic has_base;
	logic has_index;

	assign has_sib   = (modrm[`XABD_F_MOD] != `XABD_MOD_REG) && (modrm[`XABD_F_RM] == `XABD_RM_SIB);
	// A base of 101 with no displacement field means displacement only
	assign has_base  = !((modrm[`XABD_F_MOD] == `XABD_MOD_NODISP) && (sib[`XABD_F_BASE] == `XABD_BASE_DISP));
	assign has_index = sib[`XABD_F_IDX] != `XABD_IDX_NONE;

	// Scaling is free; only a second general register costs a clock
	assign two_reg  = has_sib && has_base && has_index;
	assign scale    = has_sib ? (4'h1 << sib[`XABD_F_SS]) : 4'h1;
	assign ea_undef = has_sib && !has_index && (sib[`XABD_F_SS] != `XABD_SS_ONE);

endmodule

// ### hw/xabd_decode.sv
// Notes on behaviour
// - 37: adjust after add, 4 clocks
// - D5 0A: adjust before divide, 4 clocks
// - D4 0A: adjust after multiply, 16 clocks
// - 3F: adjust after subtract, 4 clocks
// - Add-carry nibble 1, sub 010: 1/3/5
// - Add nibble 0, sub 000: 1/3/5
// - And nibble 2, sub 100, clears overflow/carry
// - 63 protected only, zero flag, 6/10/10
// - 62 bound: 11 clocks, out-of-range raises vector 5
// - 0F BC forward scan: 5/7/9 plus n
// - Reverse scan costs as forward scan
// - Bit test: BA/100 3/4/5, A3 3/6/7
// - Complement: BA/111 4/5/6, BB 5/8/9
// - Clear: BA/110 4/5/6, B3 5/8/9
// - Set: BA/101 3/5/6, AB 4/7/8
// - Two register address components add one clock
// - Misaligned operand adds 2, read-modify-write 4
// - Scale 1/2/4/8; no index needs scale 00
`timescale 1ns/1ps

`include "xabd_map.svh"

module xabd_decode
	import xabd_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       clk_en,
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	input  xabd_ctx_t       ctx,
	output logic            byte_ready_r,
	output logic            busy_r,
	output logic            done_r,
	output xabd_result_t    result_r
);

	// ****************************************
	// Declarations
	// ****************************************
	xabd_state_t  state_r;
	xabd_state_t  state_nxt;
	xabd_op_t     op_r;
	xabd_op_t     op_nxt;
	xabd_form_t   form_r;
	xabd_form_t   form_nxt;
	logic [7:0]   opc_r;
	logic [7:0]   modrm_r;
	logic [7:0]   sib_r;
	logic [7:0]   cnt_r;
	logic         take;
	logic         mem_op;
	logic         rmw;
	logic         two_reg;
	logic [3:0]   scale;
	logic         ea_undef;
	logic         bad;
	logic [7:0]   base_clk;
	logic [7:0]   extra_clk;
	xabd_result_t res_nxt;

	assign take = clk_en && byte_valid && byte_ready_r;

	function automatic xabd_op_t alu_op(input logic [3:0] hi);
		case (hi)
			`XABD_HI_ADD: alu_op = OP_ADD;
			`XABD_HI_ADC: alu_op = OP_ADD_CARRY;
			`XABD_HI_AND: alu_op = OP_BOOL_AND;
			default:      alu_op = OP_INVALID;
		endcase
	endfunction

	function automatic logic [7:0] pick(
		input logic [7:0] r,
		input logic [7:0] m,
		input logic [7:0] x,
		input logic       mem,
		input logic       miss
	);
		pick = !mem ? r : (miss ? x : m);
	endfunction

	// ****************************************
	// Byte sequencing and opcode decode
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		op_nxt    = op_r;
		form_nxt  = form_r;
		case (state_r)
			ST_OPCODE: if (take) begin
				op_nxt    = OP_INVALID;
				form_nxt  = FORM_IMPLIED;
				state_nxt = ST_LOAD;
				if (byte_data == `XABD_OPC_ADJ_ADD) begin
					op_nxt = OP_ASCII_ADJUST_AFTER_ADD;
				end else if (byte_data == `XABD_OPC_ADJ_SUB) begin
					op_nxt = OP_ASCII_ADJUST_AFTER_SUBTRACT;
				end else if (byte_data == `XABD_OPC_ADJ_DIV) begin
					op_nxt    = OP_ASCII_ADJUST_BEFORE_DIVIDE;
					state_nxt = ST_ASCII_BASE;
				end else if (byte_data == `XABD_OPC_ADJ_MUL) begin
					op_nxt    = OP_ASCII_ADJUST_AFTER_MULTIPLY;
					state_nxt = ST_ASCII_BASE;
				end else if (byte_data == `XABD_OPC_ESC) begin
					state_nxt = ST_ESCAPE;
				end else if (byte_data == `XABD_OPC_PRIV) begin
					op_nxt    = OP_PRIVILEGE_LEVEL_ADJUST;
					form_nxt  = FORM_RM_REG;
					state_nxt = ST_MODRM;
				end else if (byte_data == `XABD_OPC_BOUND) begin
					op_nxt    = OP_BOUND_CHECK;
					form_nxt  = FORM_RM_REG;
					state_nxt = ST_MODRM;
				end else if (byte_data[`XABD_F_HI] == `XABD_HI_IMM_GRP &&
				             byte_data[`XABD_F_LO_GRP] == `XABD_LO_MODRM_GRP) begin
					// Operation comes from the sub-opcode in the next byte
					form_nxt  = FORM_IMM_TO_RM;
					state_nxt = ST_MODRM;
				end else if (byte_data[`XABD_F_LO_GRP] == `XABD_LO_MODRM_GRP) begin
					op_nxt    = alu_op(byte_data[`XABD_F_HI]);
					form_nxt  = byte_data[`XABD_B_D] ? FORM_MEM_TO_REG : FORM_REG_TO_MEM;
					state_nxt = (op_nxt == OP_INVALID) ? ST_LOAD : ST_MODRM;
				end else if (byte_data[`XABD_F_LO_ACC] == `XABD_LO_IMM_ACC) begin
					op_nxt   = alu_op(byte_data[`XABD_F_HI]);
					form_nxt = FORM_IMM_TO_ACC;
				end
			end
			ST_ASCII_BASE: if (take) begin
				// Only base ten is part of this decode
				if (byte_data != `XABD_OPC_ADJ_BASE) begin
					op_nxt = OP_INVALID;
				end
				state_nxt = ST_LOAD;
			end
			ST_ESCAPE: if (take) begin
				form_nxt  = FORM_RM_REG;
				state_nxt = ST_MODRM;
				case (byte_data)
					`XABD_OPC_SCAN_FWD: op_nxt = OP_FORWARD_BIT_SCAN;
					`XABD_OPC_SCAN_REV: op_nxt = OP_REVERSE_BIT_SCAN;
					`XABD_OPC_BIT_TEST: op_nxt = OP_BIT_TEST;
					`XABD_OPC_BIT_CPL:  op_nxt = OP_BIT_TEST_COMPLEMENT;
					`XABD_OPC_BIT_CLR:  op_nxt = OP_BIT_TEST_CLEAR;
					`XABD_OPC_BIT_SET:  op_nxt = OP_BIT_TEST_SET;
					`XABD_OPC_BIT_GRP:  form_nxt = FORM_RM_IMM;
					default: begin
						op_nxt    = OP_INVALID;
						form_nxt  = FORM_IMPLIED;
						state_nxt = ST_LOAD;
					end
				endcase
			end
			ST_MODRM: if (take) begin
				if (form_r == FORM_IMM_TO_RM) begin
					case (byte_data[`XABD_F_REG])
						`XABD_SUB_ADD: op_nxt = OP_ADD;
						`XABD_SUB_ADC: op_nxt = OP_ADD_CARRY;
						`XABD_SUB_AND: op_nxt = OP_BOOL_AND;
						default:       op_nxt = OP_INVALID;
					endcase
				end else if (form_r == FORM_RM_IMM) begin
					case (byte_data[`XABD_F_REG])
						`XABD_SUB_BIT_TEST: op_nxt = OP_BIT_TEST;
						`XABD_SUB_BIT_SET:  op_nxt = OP_BIT_TEST_SET;
						`XABD_SUB_BIT_CLR:  op_nxt = OP_BIT_TEST_CLEAR;
						`XABD_SUB_BIT_CPL:  op_nxt = OP_BIT_TEST_COMPLEMENT;
						default:            op_nxt = OP_INVALID;
					endcase
				end else if (byte_data[`XABD_F_MOD] == `XABD_MOD_REG &&
				             (form_r == FORM_REG_TO_MEM || form_r == FORM_MEM_TO_REG)) begin
					form_nxt = FORM_REG_REG;
				end
				if (byte_data[`XABD_F_MOD] != `XABD_MOD_REG && byte_data[`XABD_F_RM] == `XABD_RM_SIB) begin
					state_nxt = ST_SIB;
				end else begin
					state_nxt = ST_LOAD;
				end
			end
			ST_SIB: if (take) begin
				state_nxt = ST_LOAD;
			end
			ST_LOAD: state_nxt = ST_EXEC;
			ST_EXEC: if (cnt_r == `XABD_CNT_LAST) begin
				state_nxt = ST_OPCODE;
			end
			default: state_nxt = ST_OPCODE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r      <= ST_OPCODE;
			op_r         <= OP_INVALID;
			form_r       <= FORM_IMPLIED;
			byte_ready_r <= 1'b1;
			busy_r       <= 1'b0;
		end else if (clk_en) begin
			state_r      <= state_nxt;
			op_r         <= op_nxt;
			form_r       <= form_nxt;
			byte_ready_r <= !(state_nxt == ST_LOAD || state_nxt == ST_EXEC);
			busy_r       <= state_nxt == ST_LOAD || state_nxt == ST_EXEC;
		end
	end

	// ****************************************
	// Captured instruction bytes
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			opc_r   <= `XABD_MODRM_NONE;
			modrm_r <= `XABD_MODRM_NONE;
			sib_r   <= `XABD_SIB_NONE;
		end else if (clk_en && take) begin
			case (state_r)
				ST_OPCODE: begin
					opc_r   <= byte_data;
					// Forms without an address byte look like a register operand
					modrm_r <= `XABD_MODRM_NONE;
					sib_r   <= `XABD_SIB_NONE;
				end
				ST_ESCAPE: opc_r   <= byte_data;
				ST_MODRM:  modrm_r <= byte_data;
				ST_SIB:    sib_r   <= byte_data;
				default:   opc_r   <= opc_r;
			endcase
		end
	end

	xabd_ea_cost u_ea (
		.modrm    (modrm_r),
		.sib      (sib_r),
		.two_reg  (two_reg),
		.scale    (scale),
		.ea_undef (ea_undef)
	);

	// ****************************************
	// Clock count
	// ****************************************
	assign mem_op = modrm_r[`XABD_F_MOD] != `XABD_MOD_REG;
	assign rmw    = (op_r == OP_PRIVILEGE_LEVEL_ADJUST) || (op_r == OP_BIT_TEST_COMPLEMENT) ||
	                (op_r == OP_BIT_TEST_CLEAR) || (op_r == OP_BIT_TEST_SET) ||
	                (form_r == FORM_REG_TO_MEM) || (form_r == FORM_IMM_TO_RM);

	always_comb begin
		base_clk = `XABD_CLK_INVALID;
		bad      = 1'b0;
		case (op_r)
			OP_ASCII_ADJUST_AFTER_ADD, OP_ASCII_ADJUST_AFTER_SUBTRACT,
			OP_ASCII_ADJUST_BEFORE_DIVIDE:  base_clk = `XABD_CLK_ASCII;
			OP_ASCII_ADJUST_AFTER_MULTIPLY: base_clk = `XABD_CLK_ASCII_MUL;
			OP_ADD, OP_ADD_CARRY, OP_BOOL_AND: begin
				base_clk = pick(`XABD_CLK_ALU_REG, `XABD_CLK_ALU_MEM, `XABD_CLK_ALU_MISS, mem_op, ctx.cache_miss);
			end
			OP_PRIVILEGE_LEVEL_ADJUST: begin
				// Not available in real mode: retired as invalid
				bad      = !ctx.prot_mode;
				base_clk = bad ? `XABD_CLK_INVALID :
				           pick(`XABD_CLK_PRIV_REG, `XABD_CLK_PRIV_MEM, `XABD_CLK_PRIV_MISS, mem_op, ctx.cache_miss);
			end
			OP_BOUND_CHECK: begin
				// The bounds pair lives in memory; a register operand is illegal
				bad      = !mem_op;
				base_clk = bad ? `XABD_CLK_INVALID : `XABD_CLK_BOUND;
			end
			OP_FORWARD_BIT_SCAN, OP_REVERSE_BIT_SCAN: begin
				base_clk = pick(`XABD_CLK_SCAN_REG, `XABD_CLK_SCAN_MEM, `XABD_CLK_SCAN_MISS, mem_op, ctx.cache_miss)
				           + 8'(ctx.scan_n);
			end
			OP_BIT_TEST: begin
				base_clk = (form_r == FORM_RM_IMM) ?
				           pick(`XABD_CLK_BTI_REG, `XABD_CLK_BTI_MEM, `XABD_CLK_BTI_MISS, mem_op, ctx.cache_miss) :
				           pick(`XABD_CLK_BTR_REG, `XABD_CLK_BTR_MEM, `XABD_CLK_BTR_MISS, mem_op, ctx.cache_miss);
			end
			OP_BIT_TEST_COMPLEMENT, OP_BIT_TEST_CLEAR: begin
				base_clk = (form_r == FORM_RM_IMM) ?
				           pick(`XABD_CLK_MODI_REG, `XABD_CLK_MODI_MEM, `XABD_CLK_MODI_MISS, mem_op, ctx.cache_miss) :
				           pick(`XABD_CLK_MODR_REG, `XABD_CLK_MODR_MEM, `XABD_CLK_MODR_MISS, mem_op, ctx.cache_miss);
			end
			OP_BIT_TEST_SET: begin
				base_clk = (form_r == FORM_RM_IMM) ?
				           pick(`XABD_CLK_SETI_REG, `XABD_CLK_SETI_MEM, `XABD_CLK_SETI_MISS, mem_op, ctx.cache_miss) :
				           pick(`XABD_CLK_SETR_REG, `XABD_CLK_SETR_MEM, `XABD_CLK_SETR_MISS, mem_op, ctx.cache_miss);
			end
			default: bad = 1'b1;
		endcase
	end

	always_comb begin
		extra_clk = `XABD_CLK_ZERO;
		if (mem_op && !bad) begin
			extra_clk = (two_reg ? `XABD_CLK_EA_TWO : `XABD_CLK_ZERO)
			          + (!ctx.misaligned ? `XABD_CLK_ZERO :
			             (rmw ? `XABD_CLK_MIS_RMW : `XABD_CLK_MIS_RW));
		end
	end

	// ****************************************
	// Result assembly
	// ****************************************
	always_comb begin
		res_nxt                      = '0;
		res_nxt.op                   = bad ? OP_INVALID : op_r;
		res_nxt.form                 = form_r;
		res_nxt.mem_operand          = mem_op && !bad;
		res_nxt.invalid              = bad;
		res_nxt.clocks               = base_clk + extra_clk;
		// Bit and scan operations are always full size
		res_nxt.full_width           = 1'b1;
		if (op_r == OP_ADD || op_r == OP_ADD_CARRY || op_r == OP_BOOL_AND) begin
			res_nxt.full_width  = opc_r[`XABD_B_W];
			res_nxt.reg_is_dest = (form_r != FORM_IMM_TO_RM) && (form_r != FORM_IMM_TO_ACC) &&
			                      opc_r[`XABD_B_D];
			res_nxt.sign_ext_imm = (form_r == FORM_IMM_TO_RM) && opc_r[`XABD_B_S];
		end else if (op_r == OP_ASCII_ADJUST_AFTER_ADD || op_r == OP_ASCII_ADJUST_AFTER_SUBTRACT ||
		             op_r == OP_ASCII_ADJUST_BEFORE_DIVIDE || op_r == OP_ASCII_ADJUST_AFTER_MULTIPLY) begin
			res_nxt.full_width = 1'b0;
		end
		res_nxt.clear_overflow_carry = (op_r == OP_BOOL_AND);
		res_nxt.mod_zero_flag        = (op_r == OP_PRIVILEGE_LEVEL_ADJUST) && !bad;
		res_nxt.raise_vector         = (op_r == OP_BOUND_CHECK) && !bad && ctx.out_of_range;
		res_nxt.vector               = res_nxt.raise_vector ? `XABD_BOUND_VEC : `XABD_CLK_ZERO;
		res_nxt.scale                = scale;
		res_nxt.ea_undefined         = mem_op && ea_undef;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			result_r <= '0;
		end else if (clk_en && state_r == ST_LOAD) begin
			result_r <= res_nxt;
		end
	end

	// ****************************************
	// Execution countdown
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_r <= `XABD_CLK_ZERO;
		end else if (clk_en) begin
			if (state_r == ST_LOAD) begin
				cnt_r <= res_nxt.clocks;
			end else if (state_r == ST_EXEC) begin
				cnt_r <= cnt_r - `XABD_CNT_LAST;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			done_r <= 1'b0;
		end else if (clk_en) begin
			done_r <= (state_r == ST_EXEC) && (cnt_r == `XABD_CNT_LAST);
		end
	end

endmodule

// ### verification/xabd_decode_checker.sv
`timescale 1ns/1ps

// ****************************************
// Port checker
// ****************************************
module xabd_decode_checker
	import xabd_pkg::*;
(
	input wire logic         ref_clk,
	input wire logic         srst,
	input wire logic         clk_en,
	input wire logic         byte_valid,
	input wire logic [7:0]   byte_data,
	input wire xabd_ctx_t    ctx,
	input wire logic         byte_ready_r,
	input wire logic         busy_r,
	input wire logic         done_r,
	input wire xabd_result_t result_r
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_done_one_pulse: assert property (done_r && clk_en |=> !done_r)
		else $error("done held longer than one cycle");
	a_busy_blocks_take: assert property (busy_r |-> !byte_ready_r)
		else $error("byte port ready while busy");
	a_busy_end_done: assert property (clk_en && $fell(busy_r) |-> done_r)
		else $error("busy ended without retire");
	a_busy_min_span: assert property ($rose(busy_r) |-> busy_r[*2])
		else $error("busy shorter than one exec cycle");
	a_and_clears_flags: assert property (done_r && result_r.op == OP_BOOL_AND |->
		result_r.clear_overflow_carry)
		else $error("and does not clear overflow and carry");
	a_priv_zero_flag: assert property (done_r && result_r.op == OP_PRIVILEGE_LEVEL_ADJUST |->
		result_r.mod_zero_flag && result_r.clocks >= 8'h06)
		else $error("privilege adjust flag or cost wrong");
	a_bound_vector: assert property (done_r && result_r.raise_vector |->
		result_r.op == OP_BOUND_CHECK && result_r.vector == 8'h05)
		else $error("vector raised wrongly");
	a_ascii_cost: assert property (done_r && result_r.op inside {OP_ASCII_ADJUST_AFTER_ADD,
		OP_ASCII_ADJUST_BEFORE_DIVIDE, OP_ASCII_ADJUST_AFTER_SUBTRACT} |-> result_r.clocks == 8'h04)
		else $error("ascii adjust cost wrong");
	a_mul_cost: assert property (done_r && result_r.op == OP_ASCII_ADJUST_AFTER_MULTIPLY |->
		result_r.clocks == 8'h10)
		else $error("multiply adjust cost wrong");
	a_scale_power: assert property (done_r |-> result_r.scale inside {4'h1, 4'h2, 4'h4, 4'h8})
		else $error("scale not a power of two");
endmodule

bind xabd_decode xabd_decode_checker xabd_decode_checker_i (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
	.byte_valid(byte_valid), .byte_data(byte_data), .ctx(ctx), .byte_ready_r(byte_ready_r),
	.busy_r(busy_r), .done_r(done_r), .result_r(result_r));

// ### verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	import xabd_pkg::*;
	logic         ref_clk = 1'b0;
	logic         srst = 1'b1;
	logic         clk_en = 1'b1;
	logic         byte_valid = 1'b0;
	logic [7:0]   byte_data = 8'h00;
	xabd_ctx_t    ctx = '0;
	logic         byte_ready_r, busy_r, done_r;
	xabd_result_t result_r;
	int           fail_count = 0;
	int           n_tests = 0;
	// Edges with the clock enable held low after the last byte of a run
	int           freeze = 0;
	// ****************************************
	// Op, opcode, second byte, sub, costs reg/mem/miss, flags (modrm, rmw)
	// ****************************************
	logic [43:0]  tbl [22] = '{44'h1_37_00_0_04_4_4_0, 44'h4_3f_00_0_04_4_4_0, 44'h2_d5_0a_0_04_4_4_0,
		44'h3_d4_0a_0_10_4_4_0, 44'h5_01_00_0_01_3_5_3, 44'h6_13_00_0_01_3_5_2, 44'h7_21_00_0_01_3_5_3,
		44'h6_81_00_2_01_3_5_3, 44'h7_80_00_4_01_3_5_3, 44'h5_83_00_0_01_3_5_3, 44'h8_63_00_0_06_a_a_3,
		44'h9_62_00_0_0b_b_b_2, 44'ha_0f_bc_0_05_7_9_2, 44'hb_0f_bd_0_05_7_9_2, 44'hc_0f_ba_4_03_4_5_2,
		44'hc_0f_a3_0_03_6_7_2, 44'hd_0f_ba_7_04_5_6_3, 44'hd_0f_bb_0_05_8_9_3, 44'he_0f_ba_6_04_5_6_3,
		44'he_0f_b3_0_05_8_9_3, 44'hf_0f_ba_5_03_5_6_3, 44'hf_0f_ab_0_04_7_8_3};

	always #10 ref_clk = ~ref_clk;

	xabd_decode xabd_decode_i (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .byte_valid(byte_valid),
		.byte_data(byte_data), .ctx(ctx), .byte_ready_r(byte_ready_r), .busy_r(busy_r), .done_r(done_r),
		.result_r(result_r));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Width, direction and sign flags expected for one table entry
	function automatic logic [2:0] exp_flags(input logic [43:0] e);
		logic alu;
		alu = e[43:40] inside {4'h5, 4'h6, 4'h7};
		exp_flags = {alu ? e[32] : !(e[43:40] inside {4'h1, 4'h2, 4'h3, 4'h4}),
			alu && e[39:36] != 4'h8 && e[33], alu && e[39:36] == 4'h8 && e[33]};
	endfunction

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Byte held until an edge that sees ready high
	task automatic put(input logic [7:0] b);
		int k;
		byte_valid <= 1'b1;
		byte_data <= b;
		for (k = 0; k < 50; k++) begin
			@(posedge ref_clk);
			if (byte_ready_r === 1'b1) break;
		end
		if (k == 50) begin
			fail_count++;
			stop_test();
		end
	endtask

	task automatic run(input logic [31:0] bs, input int nb, input xabd_ctx_t c, input logic [3:0] eop,
		input logic [7:0] eclk, input logic einv, input logic evec, input logic [3:0] esc);
		int n;
		ctx <= c;
		for (int i = 0; i < nb; i++) put(bs[31-8*i -: 8]);
		byte_valid <= 1'b0;
		// A frozen block must not advance, so done still comes C+2 enabled edges later
		if (freeze > 0) begin
			clk_en <= 1'b0;
			repeat (freeze) @(posedge ref_clk);
			clk_en <= 1'b1;
		end
		for (n = 1; n < 300; n++) begin
			@(posedge ref_clk);
			if (done_r === 1'b1) break;
		end
		chk(16'(n), 16'(eclk) + 16'h0002);
		chk(16'(result_r.op), 16'(eop));
		chk(16'(result_r.clocks), 16'(eclk));
		chk(16'(result_r.invalid), 16'(einv));
		chk(16'(result_r.raise_vector), 16'(evec));
		chk(16'(result_r.vector), evec ? 16'h0005 : 16'h0000);
		if (esc != 4'h0) chk(16'(result_r.scale), 16'(esc));
		if (n == 300) begin
			fail_count++;
			stop_test();
		end
	endtask

	initial begin
		logic [43:0] e;
		logic        mem, inv;
		logic [7:0]  clk, m;
		xabd_ctx_t   c;
		void'($urandom(32'h169e51d9));
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		for (int t = 0; t < 200; t++) begin
			e = tbl[$urandom % 22];
			c = 10'($urandom);
			mem = e[1] && ($urandom % 2 == 1);
			m = {mem ? 2'b00 : 2'b11, e[22:20], 3'($urandom % 4)};
			inv = (e[43:40] == 4'h8 && !c.prot_mode) || (e[43:40] == 4'h9 && !mem);
			clk = !mem ? e[19:12] : c.cache_miss ? 8'(e[7:4]) : 8'(e[11:8]);
			if (mem && c.misaligned) clk += e[0] ? 8'h04 : 8'h02;
			if (e[43:41] == 3'b101) clk += 8'(c.scan_n);
			if (inv) clk = 8'h01;
			run(e[31:24] != 8'h00 ? {e[39:24], m, 8'h00} : {e[39:32], m, 16'h0000},
				1 + int'(e[31:24] != 8'h00) + int'(e[1]), c, inv ? 4'h0 : e[43:40], clk, inv,
				!inv && e[43:40] == 4'h9 && c.out_of_range, 4'h0);
			chk(16'({result_r.full_width, result_r.reg_is_dest, result_r.sign_ext_imm}), 16'(exp_flags(e)));
			chk(16'(result_r.mem_operand), 16'(mem && !inv));
		end
		$display("test random done");
		c = '0;
		c.cache_miss = 1'b1;
		c.misaligned = 1'b1;
		run({8'h01, 8'h04, 8'h08, 8'h00}, 3, c, 4'h5, 8'h0a, 1'b0, 1'b0, 4'h1);
		run({8'h03, 8'h04, 8'hc8, 8'h00}, 3, '0, 4'h5, 8'h04, 1'b0, 1'b0, 4'h8);
		chk(16'(result_r.ea_undefined), 16'h0000);
		run({8'h03, 8'h04, 8'h60, 8'h00}, 3, '0, 4'h5, 8'h03, 1'b0, 1'b0, 4'h2);
		chk(16'(result_r.ea_undefined), 16'h0001);
		for (int h = 0; h < 3; h++) run({4'(h), 4'h5, 24'h0}, 1, '0, 4'(5 + h), 8'h01, 1'b0, 1'b0, 4'h0);
		$display("test sib and accumulator done");
		run({8'hf4, 24'h0}, 1, '0, 4'h0, 8'h01, 1'b1, 1'b0, 4'h0);
		run({8'h27, 24'h0}, 1, '0, 4'h0, 8'h01, 1'b1, 1'b0, 4'h0);
		run({8'h0f, 8'hba, 8'hc0, 8'h00}, 3, '0, 4'h0, 8'h01, 1'b1, 1'b0, 4'h0);
		$display("test refused forms done");
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		run({8'hd4, 8'h0a, 16'h0}, 2, '0, 4'h3, 8'h10, 1'b0, 1'b0, 4'h0);
		$display("test reset recovery done");
		freeze = 3;
		run({8'h37, 24'h0}, 1, '0, 4'h1, 8'h04, 1'b0, 1'b0, 4'h0);
		$display("test clock enable done");
		stop_test();
	end
endmodule
